// ---- logic/mmcs_pkg.sv ----
// Constants for the MAC mode control and status block
// Overview of operation
// - Received pause frames pause transmit only when obeyed
// - Half duplex back-pressure forces collisions on trigger
// - Full duplex back-pressure sends pause frames on trigger
// - Back-pressure disabled means no collisions, no pause frames sent and no receive flow status
// - Loopback forces internal loop and full duplex
// - High-rate mode forces full duplex
// - Duplex bit chooses half or full otherwise
// - Idle bit reads 0 in reset, after it 1 when engine quiet and idle requested or media not released
// - Transmit fault code: 0 none, 1 start, 2 ownership
// - Flagged host fault holds until hardware reset
// - Zero packet length is never flagged
// - Idle request bit answered through idle status
// - Fault channel field clears on status read unless a fault is captured in that cycle
`default_nettype none
package mmcs_pkg;
   // Register map, byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   // Control field positions
   localparam int CTRL_FULL_DUPLEX_BIT = 0;
   localparam int CTRL_LOOPBACK_BIT = 1;
   localparam int CTRL_BUF_FLOW_BIT = 3;
   localparam int CTRL_TX_FLOW_BIT = 4;
   localparam int CTRL_MEDIA_REL_BIT = 5;
   localparam int CTRL_HIGH_RATE_BIT = 7;
   localparam int CTRL_CMD_IDLE_BIT = 11;
   // Writable control bits and reset value
   localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_08bb;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Status field positions
   localparam int ST_IDLE_BIT = 31;
   localparam int ST_CODE_LSB = 20;
   localparam int ST_CHAN_LSB = 16;
   localparam int ST_PIN_RATE_BIT = 4;
   localparam int ST_PIN_DUPLEX_BIT = 3;
   localparam int ST_QOS_BIT = 2;
   localparam int ST_RX_PAUSE_BIT = 1;
   localparam int ST_TX_PAUSE_BIT = 0;
   // Transmit host fault codes
   localparam logic [3:0] FAULT_NONE = 4'h0;
   localparam logic [3:0] FAULT_SOP_MISSING = 4'h1;
   localparam logic [3:0] FAULT_OWNER_CLEAR = 4'h2;
   localparam logic [2:0] CHAN_RESET = 3'h0;
   // Timing: pause quantum is 512 bit times at 100 Mbit/s
   localparam int CLK_PERIOD_NS = 50;
   localparam int PAUSE_QUANTUM_NS = 5120;
   localparam int PAUSE_QUANTUM_CYCLES = (PAUSE_QUANTUM_NS / CLK_PERIOD_NS < 1) ? 1 :
      PAUSE_QUANTUM_NS / CLK_PERIOD_NS;
   localparam int QDIV_W = 7;
   localparam logic [QDIV_W-1:0] QDIV_LAST = QDIV_W'(PAUSE_QUANTUM_CYCLES - 1);
   localparam int QUANTA_W = 16;
endpackage
`default_nettype wire

// ---- logic/mmcs_fault_if.sv ----
// Interface between the register side and the transmit fault capture
`default_nettype none
interface mmcs_fault_if;
   logic sop_missing; // Start flag missing on first buffer
   logic owner_clear; // Ownership flag clear in start buffer
   logic zero_len; // Zero packet length seen
   logic [2:0] chan_in; // Channel of the event
   logic read_clear; // Status register read
   logic [3:0] code; // Held fault code
   logic [2:0] chan; // Held fault channel
   modport reporter (output sop_missing, owner_clear, zero_len, chan_in, read_clear, input code, chan);
   modport capture (input sop_missing, owner_clear, zero_len, chan_in, read_clear, output code, chan);
endinterface
`default_nettype wire

// ---- logic/mmcs_fault_capture.sv ----
// Sticky capture of the transmit host fault code and channel
`default_nettype none
module mmcs_fault_capture (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   mmcs_fault_if.capture flt
);
   logic take; // First fault since reset

   // Only the first reportable fault is taken; zero length never is
   assign take = (flt.code == mmcs_pkg::FAULT_NONE) && (flt.sop_missing || flt.owner_clear);

   // Code stays until hardware reset
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flt.code <= mmcs_pkg::FAULT_NONE;
      end else if (take) begin
         flt.code <= flt.sop_missing ? mmcs_pkg::FAULT_SOP_MISSING : mmcs_pkg::FAULT_OWNER_CLEAR;
      end
   end

   // Channel clears on read, but a capture in the same cycle wins
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flt.chan <= mmcs_pkg::CHAN_RESET;
      end else if (take) begin
         flt.chan <= flt.chan_in;
      end else if (flt.read_clear) begin
         flt.chan <= mmcs_pkg::CHAN_RESET;
      end
   end

   // Held code never changes once set
   property p_code_sticky;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (flt.code != mmcs_pkg::FAULT_NONE) |=> $stable(flt.code);
   endproperty
   a_code_sticky: assert property (p_code_sticky) else $error("fault code changed");

   // Zero length alone leaves the code clear
   property p_zero_len_silent;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (flt.code == mmcs_pkg::FAULT_NONE) && flt.zero_len && !flt.sop_missing && !flt.owner_clear
      |=> (flt.code == mmcs_pkg::FAULT_NONE);
   endproperty
   a_zero_len_silent: assert property (p_zero_len_silent) else $error("zero length flagged");

   // Start-flag fault reported as code 1
   property p_sop_code;
      @(posedge mclk_i) disable iff (!rst_n_i)
      take && flt.sop_missing |=> (flt.code == 4'h1) && (flt.chan == $past(flt.chan_in));
   endproperty
   a_sop_code: assert property (p_sop_code) else $error("start fault code wrong");

   c_fault: cover property (@(posedge mclk_i) disable iff (!rst_n_i) take);
endmodule
`default_nettype wire

// ---- logic/mmcs_pause_timer.sv ----
// Pause timer loaded from received pause frames, counts quanta
`default_nettype none
module mmcs_pause_timer (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic [mmcs_pkg::QUANTA_W-1:0] quanta_i,
   input wire logic tick_i,
   output logic active_o
);
   logic [mmcs_pkg::QUANTA_W-1:0] remain; // Quanta still to wait

   // Load wins over the count down; zero quanta ends a pause early
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         remain <= '0;
      end else if (load_i) begin
         remain <= quanta_i;
      end else if (tick_i && (remain != '0)) begin
         remain <= remain - 1'b1;
      end
   end

   assign active_o = (remain != '0);
endmodule
`default_nettype wire

// ---- logic/mmcs_top.sv ----
// Top of the MAC mode control and status block
//
// Implementation choices: the register offsets and the strobed register port.
`default_nettype none
module mmcs_top (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Receive side events
   input wire logic rx_pause_valid_i,
   input wire logic [15:0] rx_pause_quanta_i,
   input wire logic rx_buf_flow_trig_i,
   input wire logic rx_flow_trig_i,
   input wire logic rx_qos_flow_i,
   // Transmit DMA events
   input wire logic engine_busy_i,
   input wire logic tx_sop_missing_i,
   input wire logic tx_owner_clear_i,
   input wire logic tx_zero_len_i,
   input wire logic [2:0] tx_fault_chan_i,
   // External indication pins
   input wire logic pin_two_way_state_i,
   input wire logic pin_high_rate_state_i,
   // Mode outputs
   output logic full_duplex_o,
   output logic loopback_o,
   output logic high_rate_mode_o,
   output logic media_release_o,
   output logic idle_request_o,
   // Flow control actions and host fault flag
   output logic tx_hold_o,
   output logic force_collision_o,
   output logic send_pause_o,
   output logic host_fault_pending_o
);
   // Control register and decoded fields
   logic [31:0] ctrl; // Mode control register
   logic ctrl_full; // Duplex select bit
   logic ctrl_loop; // Loopback bit
   logic buf_flow_en; // Receive back-pressure enable
   logic tx_flow_en; // Obey received pause frames
   logic ctrl_high; // High-rate mode bit
   logic cmd_idle; // Idle request bit

   // Status state
   logic idle_flag; // Idle report
   logic rx_pause_active; // Receive flow control applied
   logic rx_qos_flow_active; // Receive QoS flow applied
   logic tx_pause_active; // Transmitter paused
   logic [1:0] pin_meta; // First synchroniser stage
   logic [1:0] pin_sync; // Second synchroniser stage
   logic [31:0] status_word; // Assembled status word

   // Flow control helpers
   logic flow_trig_q; // Last flow trigger level
   logic pause_load; // Accept a received pause frame
   logic [mmcs_pkg::QDIV_W-1:0] qdiv; // Quantum divider
   logic quantum_tick; // One pulse per pause quantum

   // Register access helpers
   logic wr_ctrl; // Control write this cycle
   logic rd_status; // Status read this cycle

   mmcs_fault_if flt ();

   // Field decode of the control register
   assign ctrl_full = ctrl[mmcs_pkg::CTRL_FULL_DUPLEX_BIT];
   assign ctrl_loop = ctrl[mmcs_pkg::CTRL_LOOPBACK_BIT];
   assign buf_flow_en = ctrl[mmcs_pkg::CTRL_BUF_FLOW_BIT];
   assign tx_flow_en = ctrl[mmcs_pkg::CTRL_TX_FLOW_BIT];
   assign ctrl_high = ctrl[mmcs_pkg::CTRL_HIGH_RATE_BIT];
   assign cmd_idle = ctrl[mmcs_pkg::CTRL_CMD_IDLE_BIT];

   // Strobe decode
   assign wr_ctrl = reg_wr_i && (reg_addr_i == mmcs_pkg::CTRL_OFFSET);
   assign rd_status = reg_rd_i && (reg_addr_i == mmcs_pkg::STATUS_OFFSET);

   // Control register write; reserved bits stay zero
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= mmcs_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= reg_wdata_i & mmcs_pkg::CTRL_WRITE_MASK;
      end
   end

   // Mode outputs straight from control flops
   assign loopback_o = ctrl_loop;
   assign high_rate_mode_o = ctrl_high;
   assign media_release_o = ctrl[mmcs_pkg::CTRL_MEDIA_REL_BIT];
   assign idle_request_o = cmd_idle;

   // Effective duplex: loopback or high rate force full
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         full_duplex_o <= 1'b0;
      end else if (ctrl_loop || ctrl_high) begin
         full_duplex_o <= 1'b1;
      end else begin
         full_duplex_o <= ctrl_full;
      end
   end

   // Pin synchronisers, first stage read only by the second
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
      end else begin
         pin_meta <= {pin_high_rate_state_i, pin_two_way_state_i};
         pin_sync <= pin_meta;
      end
   end

   // Quantum divider, free running one-cycle enable
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         qdiv <= '0;
      end else if (qdiv == mmcs_pkg::QDIV_LAST) begin
         qdiv <= '0;
      end else begin
         qdiv <= qdiv + 1'b1;
      end
   end
   assign quantum_tick = (qdiv == mmcs_pkg::QDIV_LAST);

   // Pause frames act only in full duplex with obey enabled
   assign pause_load = rx_pause_valid_i && tx_flow_en && full_duplex_o;

   // Transmit pause timer
   mmcs_pause_timer u_pause (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .load_i(pause_load),
      .quanta_i(rx_pause_quanta_i),
      .tick_i(quantum_tick),
      .active_o(tx_pause_active)
   );
   assign tx_hold_o = tx_pause_active;

   // Forced collisions in half duplex under back-pressure
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         force_collision_o <= 1'b0;
      end else begin
         force_collision_o <= buf_flow_en && !full_duplex_o && rx_buf_flow_trig_i;
      end
   end

   // Outgoing pause frame request on each new trigger in full duplex with back-pressure on
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flow_trig_q <= 1'b0;
         send_pause_o <= 1'b0;
      end else begin
         flow_trig_q <= rx_flow_trig_i;
         send_pause_o <= buf_flow_en && full_duplex_o && rx_flow_trig_i && !flow_trig_q;
      end
   end

   // Flow activity status flags
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_pause_active <= 1'b0;
         rx_qos_flow_active <= 1'b0;
      end else begin
         rx_pause_active <= buf_flow_en && (rx_buf_flow_trig_i || rx_flow_trig_i);
         rx_qos_flow_active <= buf_flow_en && rx_qos_flow_i;
      end
   end

   // Idle report: 0 in reset, 1 the cycle after when engine quiet and idle requested or media not released
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idle_flag <= 1'b0;
      end else begin
         idle_flag <= !engine_busy_i && (cmd_idle || !media_release_o);
      end
   end

   // Fault capture hookup
   assign flt.sop_missing = tx_sop_missing_i;
   assign flt.owner_clear = tx_owner_clear_i;
   assign flt.zero_len = tx_zero_len_i;
   assign flt.chan_in = tx_fault_chan_i;
   assign flt.read_clear = rd_status;

   mmcs_fault_capture u_fault (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .flt(flt)
   );
   assign host_fault_pending_o = (flt.code != mmcs_pkg::FAULT_NONE);

   // Status word assembly; reserved bits read zero
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[mmcs_pkg::ST_IDLE_BIT] = idle_flag;
      status_word[mmcs_pkg::ST_CODE_LSB +: 4] = flt.code;
      status_word[mmcs_pkg::ST_CHAN_LSB +: 3] = flt.chan;
      status_word[mmcs_pkg::ST_PIN_RATE_BIT] = pin_sync[1];
      status_word[mmcs_pkg::ST_PIN_DUPLEX_BIT] = pin_sync[0];
      status_word[mmcs_pkg::ST_QOS_BIT] = rx_qos_flow_active;
      status_word[mmcs_pkg::ST_RX_PAUSE_BIT] = rx_pause_active;
      status_word[mmcs_pkg::ST_TX_PAUSE_BIT] = tx_pause_active;
   end

   // Read data, valid in the cycle after the strobe only
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            mmcs_pkg::CTRL_OFFSET: begin
               reg_rdata_o <= ctrl;
            end
            mmcs_pkg::STATUS_OFFSET: begin
               reg_rdata_o <= status_word;
            end
            default: begin
               reg_rdata_o <= 32'h0000_0000;
            end
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

   // Checks follow

   // Transmit pause starts only from an obeyed pause frame
   property p_pause_obey;
      @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(tx_hold_o) |-> $past(rx_pause_valid_i && tx_flow_en && full_duplex_o);
   endproperty
   a_pause_obey: assert property (p_pause_obey) else $error("pause without obey");

   // Half duplex back-pressure raises a collision next cycle
   property p_force_col;
      @(posedge mclk_i) disable iff (!rst_n_i)
      buf_flow_en && !full_duplex_o && rx_buf_flow_trig_i |=> force_collision_o;
   endproperty
   a_force_col: assert property (p_force_col) else $error("collision missing");

   // Pause frame sent only in full duplex with back-pressure on
   property p_send_pause;
      @(posedge mclk_i) disable iff (!rst_n_i)
      send_pause_o |-> $past(buf_flow_en && full_duplex_o && rx_flow_trig_i);
   endproperty
   a_send_pause: assert property (p_send_pause) else $error("stray pause frame");

   // No flow action with back-pressure off
   property p_no_flow;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !buf_flow_en |=> !force_collision_o && !send_pause_o && !rx_pause_active;
   endproperty
   a_no_flow: assert property (p_no_flow) else $error("flow control while off");

   // Loopback forces full duplex
   property p_loop_full;
      @(posedge mclk_i) disable iff (!rst_n_i)
      ctrl_loop |-> loopback_o ##1 full_duplex_o;
   endproperty
   a_loop_full: assert property (p_loop_full) else $error("loopback not full duplex");

   // High rate forces full duplex
   property p_high_full;
      @(posedge mclk_i) disable iff (!rst_n_i)
      ctrl_high |=> full_duplex_o;
   endproperty
   a_high_full: assert property (p_high_full) else $error("high rate not full duplex");

   // Otherwise the duplex bit decides
   property p_duplex_bit;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !ctrl_loop && !ctrl_high |=> (full_duplex_o == $past(ctrl_full));
   endproperty
   a_duplex_bit: assert property (p_duplex_bit) else $error("duplex select ignored");

   // Status read clears the channel unless a fault is taken
   property p_chan_clear;
      @(posedge mclk_i) disable iff (!rst_n_i)
      rd_status && (flt.code != mmcs_pkg::FAULT_NONE) |=> (flt.chan == 3'h0);
   endproperty
   a_chan_clear: assert property (p_chan_clear) else $error("channel not cleared");

   // Read data returns the status word one cycle later
   property p_status_read;
      @(posedge mclk_i) disable iff (!rst_n_i)
      rd_status |=> (reg_rdata_o[31] == $past(idle_flag)) && (reg_rdata_o[23:20] == $past(flt.code));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   c_pause: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $fell(tx_hold_o));
   c_collision: cover property (@(posedge mclk_i) disable iff (!rst_n_i) force_collision_o);
   c_send: cover property (@(posedge mclk_i) disable iff (!rst_n_i) send_pause_o ##1 !send_pause_o);
   c_loop: cover property (@(posedge mclk_i) disable iff (!rst_n_i) ctrl_loop && full_duplex_o);
endmodule
`default_nettype wire

// ---- bench/mmcs_phy_model.sv ----
// Far-side model: pause frames, receive flow triggers and external pin levels
`default_nettype none
module mmcs_phy_model (
   input wire logic mclk_i,
   output logic rx_pause_valid_o,
   output logic [15:0] rx_pause_quanta_o,
   output logic rx_buf_flow_trig_o,
   output logic rx_flow_trig_o,
   output logic rx_qos_flow_o,
   output logic pin_two_way_state_o,
   output logic pin_high_rate_state_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet line at time zero
   initial begin
      rx_pause_valid_o = 1'b0;
      rx_pause_quanta_o = 16'h5a5a;
      rx_buf_flow_trig_o = 1'b0;
      rx_flow_trig_o = 1'b0;
      rx_qos_flow_o = 1'b0;
      pin_two_way_state_o = 1'b0;
      pin_high_rate_state_o = 1'b0;
   end
   // One received pause frame, valid for a single cycle
   task automatic pause_frame(input logic [15:0] quanta);
      @(posedge mclk_i);
      rx_pause_valid_o <= 1'b1;
      rx_pause_quanta_o <= quanta;
      @(posedge mclk_i);
      rx_pause_valid_o <= 1'b0;
      // Stale quanta are not held once the frame is over
      rx_pause_quanta_o <= ~quanta;
   endtask
   // Trigger and pin levels, changed just after an edge
   task automatic set_levels(input logic buf_t, input logic flow_t, input logic qos_t, input logic dup,
                             input logic rate);
      @(posedge mclk_i);
      rx_buf_flow_trig_o <= buf_t;
      rx_flow_trig_o <= flow_t;
      rx_qos_flow_o <= qos_t;
      pin_two_way_state_o <= dup;
      pin_high_rate_state_o <= rate;
   endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the MAC mode control and status block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0; // Bench clock
   logic rst_n = 1'b0; // Reset, active low
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic pv, bt, ft, qt, pd, pr; // Far-side strobes and levels
   logic [15:0] pq;
   logic busy = 1'b0;
   logic sop = 1'b0;
   logic own = 1'b0;
   logic zl = 1'b0;
   logic [2:0] chan = 3'h0;
   logic fd, lb, hr, mr, ir, hold, coll, spause, pend; // Mode and action outputs
   logic [31:0] rdata; // Last read word
   int fails = 0;
   int checks = 0;
   int n;
   // Clock, 50 ns period
   always #25 mclk = ~mclk;
   mmcs_phy_model u_mmcs_phy_model (.mclk_i(mclk), .rx_pause_valid_o(pv), .rx_pause_quanta_o(pq),
      .rx_buf_flow_trig_o(bt), .rx_flow_trig_o(ft), .rx_qos_flow_o(qt), .pin_two_way_state_o(pd),
      .pin_high_rate_state_o(pr));
   mmcs_top u_mmcs_top (.mclk_i(mclk), .rst_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .rx_pause_valid_i(pv),
      .rx_pause_quanta_i(pq), .rx_buf_flow_trig_i(bt), .rx_flow_trig_i(ft), .rx_qos_flow_i(qt),
      .engine_busy_i(busy), .tx_sop_missing_i(sop), .tx_owner_clear_i(own), .tx_zero_len_i(zl),
      .tx_fault_chan_i(chan), .pin_two_way_state_i(pd), .pin_high_rate_state_i(pr), .full_duplex_o(fd),
      .loopback_o(lb), .high_rate_mode_o(hr), .media_release_o(mr), .idle_request_o(ir), .tx_hold_o(hold),
      .force_collision_o(coll), .send_pause_o(spause), .host_fault_pending_o(pend));
   // Prints the counts and the verdict, then ends the run
   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Compare one value, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // One-cycle register read, data taken in the following cycle
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      rdata = reg_rdata;
   endtask
   // Transmit DMA event pulse with its channel
   task automatic fault(input logic s, input logic o, input logic z, input logic [2:0] c);
      @(posedge mclk);
      sop <= s;
      own <= o;
      zl <= z;
      chan <= c;
      @(posedge mclk);
      {sop, own, zl} <= 3'b000;
      chan <= ~c;
   endtask
   task automatic cycles(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   // Send pulses seen over a short span
   task automatic count_pause(output int c);
      c = 0;
      repeat (6) begin
         @(posedge mclk);
         #1;
         c += int'(spause);
      end
   endtask
   logic [31:0] modes [4] = '{32'h0, 32'h1, 32'h2, 32'h80}; // Duplex table: none, bit0, loopback, high rate
   logic [2:0] mexp [4] = '{3'b000, 3'b100, 3'b110, 3'b101}; // Expected full, loopback, high rate
   // Main sequence
   initial begin
      u_mmcs_phy_model.set_levels(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      cycles(15);
      chk(reg_rdata, 32'h0, "read data in reset");
      rst_n <= 1'b1;
      rd(mmcs_pkg::STATUS_OFFSET);
      chk(rdata[31], 1'b1, "idle after reset");
      chk(rdata[23:16], 8'h00, "fault fields after reset");
      chk(rdata[2:0], 3'h0, "flow bits after reset");
      cycles(2);
      rd(mmcs_pkg::STATUS_OFFSET);
      chk(rdata[4:3], 2'b01, "pin bits");
      u_mmcs_phy_model.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      cycles(3);
      rd(mmcs_pkg::STATUS_OFFSET);
      chk(rdata[4:3], 2'b10, "pin bits swapped");
      // Register access, loopback and media release both left low
      rd(mmcs_pkg::CTRL_OFFSET);
      chk(rdata, 32'h0, "control reset");
      wr(mmcs_pkg::CTRL_OFFSET, 32'hffff_ffdd);
      rd(mmcs_pkg::CTRL_OFFSET);
      chk(rdata, 32'h0000_0899, "control writable bits");
      rd(8'h08);
      chk(rdata, 32'h0, "unmapped read");
      // Duplex selection and forcing, loopback only changed with media held
      for (int i = 0; i < 4; i++) begin
         wr(mmcs_pkg::CTRL_OFFSET, modes[i]);
         cycles(2);
         chk({fd, lb, hr}, mexp[i], "mode outputs");
      end
      // Received pause frames
      wr(mmcs_pkg::CTRL_OFFSET, 32'h01);
      u_mmcs_phy_model.pause_frame(16'h0002);
      cycles(2);
      chk(hold, 1'b0, "pause ignored");
      wr(mmcs_pkg::CTRL_OFFSET, 32'h11);
      u_mmcs_phy_model.pause_frame(16'h0002);
      #1;
      chk(hold, 1'b1, "pause obeyed");
      rd(mmcs_pkg::STATUS_OFFSET);
      chk(rdata[0], 1'b1, "tx pause status");
      n = 2;
      while (hold === 1'b1 && n < 300) begin
         cycles(1);
         n++;
      end
      if (n >= 300) begin
         fails++;
         $display("wrong value at %0t: pause never ended", $time);
         tally_and_finish();
      end
      chk(n >= 100 && n <= 210, 1'b1, "pause length");
      u_mmcs_phy_model.pause_frame(16'h0040);
      #1;
      chk(hold, 1'b1, "pause reloaded");
      u_mmcs_phy_model.pause_frame(16'h0000);
      cycles(1);
      chk(hold, 1'b0, "zero quanta ends pause");
      wr(mmcs_pkg::CTRL_OFFSET, 32'h10);
      cycles(2);
      u_mmcs_phy_model.pause_frame(16'h0002);
      #1;
      chk(hold, 1'b0, "half duplex ignores pause");
      // Back-pressure in half and full duplex
      wr(mmcs_pkg::CTRL_OFFSET, 32'h08);
      u_mmcs_phy_model.set_levels(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      cycles(2);
      chk({coll, spause}, 2'b10, "forced collision");
      rd(mmcs_pkg::STATUS_OFFSET);
      chk(rdata[2:1], 2'b11, "rx flow and qos status");
      wr(mmcs_pkg::CTRL_OFFSET, 32'h00);
      cycles(2);
      chk(coll, 1'b0, "no collision when disabled");
      u_mmcs_phy_model.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      wr(mmcs_pkg::CTRL_OFFSET, 32'h09);
      u_mmcs_phy_model.set_levels(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      count_pause(n);
      chk(n, 1, "one pause frame sent");
      chk(coll, 1'b0, "no collision in full duplex");
      u_mmcs_phy_model.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      wr(mmcs_pkg::CTRL_OFFSET, 32'h01);
      u_mmcs_phy_model.set_levels(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      count_pause(n);
      chk(n, 0, "no pause frame when disabled");
      // Idle reporting
      busy <= 1'b1;
      cycles(2);
      rd(mmcs_pkg::STATUS_OFFSET);
      chk(rdata[31], 1'b0, "busy not idle");
      busy <= 1'b0;
      wr(mmcs_pkg::CTRL_OFFSET, 32'h20);
      rd(mmcs_pkg::STATUS_OFFSET);
      chk(rdata[31], 1'b0, "running not idle");
      chk({mr, ir}, 2'b10, "media release without idle request");
      wr(mmcs_pkg::CTRL_OFFSET, 32'h820);
      rd(mmcs_pkg::STATUS_OFFSET);
      chk(rdata[31], 1'b1, "idle on request");
      chk({mr, ir}, 2'b11, "media release and idle request");
      // Transmit host faults
      fault(1'b0, 1'b0, 1'b1, 3'h3);
      rd(mmcs_pkg::STATUS_OFFSET);
      chk({rdata[23:16], pend}, 9'h000, "zero length unreported");
      fault(1'b1, 1'b0, 1'b0, 3'h5);
      rd(mmcs_pkg::STATUS_OFFSET);
      chk({rdata[23:16], pend}, 9'h02b, "start flag fault");
      rd(mmcs_pkg::STATUS_OFFSET);
      chk(rdata[23:16], 8'h10, "channel cleared by read");
      fault(1'b0, 1'b1, 1'b0, 3'h2);
      wr(mmcs_pkg::STATUS_OFFSET, 32'h0);
      wr(mmcs_pkg::CTRL_OFFSET, 32'h0);
      rd(mmcs_pkg::STATUS_OFFSET);
      chk({rdata[23:20], pend}, 5'h03, "fault held");
      // Second reset in mid-run
      rst_n <= 1'b0;
      cycles(2);
      chk(reg_rdata, 32'h0, "read data in second reset");
      chk({fd, pend}, 2'b00, "outputs in reset");
      rst_n <= 1'b1;
      rd(mmcs_pkg::STATUS_OFFSET);
      chk({rdata[31], rdata[23:20]}, 5'h10, "fault cleared by reset");
      fault(1'b0, 1'b1, 1'b0, 3'h7);
      rd(mmcs_pkg::STATUS_OFFSET);
      chk(rdata[23:16], 8'h27, "ownership fault");
      tally_and_finish();
   end
endmodule
`default_nettype wire
